/* src/ccmcs_top.sv */
// control space and address space decoding of the cache/mmu unit
//
// Notes on behaviour
// - identifier 0x1 goes straight to extended bus physical space
// - identifier 0x6 reaches tlb diagnostic view, not memory
// - identifiers 0x10-0x14 flush lines by page, segment, region, context, user
// - identifiers 0x20-0x2F bypass translation, address used as physical
// - control registers decode at listed offsets 0x0 through 0x1400
// - cache is 0x10000 bytes in 32-byte lines
// - page flush covers 64 lines, segment 256, context 4096
// - control register has copy-back, cache enable and translation enable
// - with translation off, separate cacheable bits for fetches and data
// - control bit signals or suppresses data access exceptions
// - replacement counter is below initial counter only for a cycle after a write, locking low entries
// - reset register reports watchdog, internal or external software reset; writable
// - fault status holds table-walk level of the fault
// - up to four units cascade, each owning its own cache slice
// - boot-mode unit answers all addresses, before and after units initialised; straps pick it
// - in multichip mode only boot-mode unit drives memory bus and translates; with it off any unit does
// - in multichip mode each non-boot unit answers only its address slice from address, mask, valid
// - snooping variant holds module identifier in control bits 18:15
// - snooping variant bit 11 enables reflective memory
// - base variant bit 9 locks cache; snooping variant has no lock
`timescale 1ns/1ps
`default_nettype none
module ccmcs_top
    import ccmcs_pkg::*;
#(
    parameter bit SNOOP_VARIANT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_asi,
    input  wire logic [31:0] req_addr,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [31:0]      rsp_rdata,
    output ccmcs_pkg::ccmcs_route_t rsp_route,
    output logic             rsp_mine,
    output logic             bus_req,
    output logic [31:0]      bus_addr,
    output logic             bus_physical,
    output logic             diag_sel,
    output logic             flush_busy,
    output logic             inst_cacheable,
    output logic             data_cacheable,
    output logic             fault_signal,
    output logic             fault_to_cpu,
    output logic             cache_locked,
    output logic             reflect_en,
    output logic [3:0]       module_id,
    output logic [5:0]       tlb_victim,
    input  wire logic        chip_select_strap,
    input  wire logic        hold_strap,
    input  wire logic        output_enable_strap,
    input  wire logic        tlb_refill,
    input  wire logic        fault_event,
    input  wire logic        fault_async,
    input  wire logic [1:0]  fault_level,
    input  wire logic [7:0]  fault_type,
    input  wire logic [31:0] fault_addr,
    input  wire logic        wdog_reset_event,
    input  wire logic        sw_int_reset_event,
    input  wire logic        sw_ext_reset_event
);
    import ccmcs_pkg::*;

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]  system_control_reg;
        logic [31:0]  context_table_ptr_reg;
        logic [31:0]  context_number_reg;
        logic [31:0]  sync_fault_status_reg;
        logic [31:0]  sync_fault_addr_reg;
        logic [31:0]  async_fault_status_reg;
        logic [31:0]  async_fault_addr_reg;
        logic [2:0]   reset_cause_reg;
        logic [31:0]  root_table_ptr_reg;
        logic [31:0]  instr_table_ptr_reg;
        logic [31:0]  data_table_ptr_reg;
        logic [31:0]  index_tag_reg;
        logic [5:0]   replacement_counter;
        logic [5:0]   initial_replacement_counter;
        logic         boot_mode;
        logic [1:0]   strap_cnt;
        logic [2:0]   strap_s1;
        logic [2:0]   strap_s2;
        logic [2:0]   evt_s1;
        logic [2:0]   evt_s2;
        logic [12:0]  flush_left;
        logic [10:0]  flush_line;
        logic [10:0]  tag_raddr;
        logic         rsp_valid;
        logic [31:0]  rsp_rdata;
        ccmcs_route_t rsp_route;
        logic         rsp_mine;
        logic         bus_req;
        logic [31:0]  bus_addr;
        logic         bus_physical;
        logic         diag_sel;
        logic         fault_signal;
    } ccmcs_state_t;

    ccmcs_state_t st_r;
    ccmcs_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////
    function automatic ccmcs_route_t route_of(input logic [7:0] asi);
        ccmcs_route_t r;
        r = CCMCS_ROUTE_NORMAL;
        if (asi == ASI_EXTENDED) begin
            r = CCMCS_ROUTE_EXT;
        end else if (asi == ASI_CTRL_SPACE) begin
            r = CCMCS_ROUTE_CTRL;
        end else if (asi == ASI_TLB_DIAG) begin
            r = CCMCS_ROUTE_DIAG;
        end else if (asi >= ASI_FLUSH_PAGE && asi <= ASI_FLUSH_USER) begin
            r = CCMCS_ROUTE_FLUSH;
        end else if (asi[7:4] == ASI_PASS_HI) begin
            r = CCMCS_ROUTE_PASS;
        end
        return r;
    endfunction : route_of

    function automatic logic [12:0] flush_lines(input logic [7:0] asi);
        logic [12:0] n;
        n = LINES_CTX;
        if (asi == ASI_FLUSH_PAGE) begin
            n = LINES_PAGE;
        end else if (asi == ASI_FLUSH_SEG) begin
            n = LINES_SEG;
        end
        return n;
    endfunction : flush_lines

    ////////////////////////////////////////////////////////////////////
    // address slice match for cascaded units
    logic [1:0]  multichip_address_field;
    logic [1:0]  multichip_mask_field;
    logic        mv;
    logic        in_slice;
    logic        mc_mode;
    logic [31:0] scr_mask;
    logic        strap_boot;
    ccmcs_route_t rq_route;
    logic        accept;
    logic [19:0] tag_rdata;

    assign multichip_address_field        = st_r.system_control_reg[SCR_MCA_LO +: 2];
    assign multichip_mask_field        = st_r.system_control_reg[SCR_MCM_LO +: 2];
    assign mv         = st_r.system_control_reg[SCR_MV];
    assign mc_mode    = st_r.system_control_reg[SCR_MC_MODE];
    // slice taken from the cache index bits above the 64K of one unit
    assign in_slice   = mv && (((req_addr[17:16] ^ multichip_address_field) & ~multichip_mask_field) == 2'h0);
    assign scr_mask   = SNOOP_VARIANT ? SCR_MASK_SNOOP : SCR_MASK_BASE;
    assign strap_boot = st_r.strap_s2[0] & ~st_r.strap_s2[1] & st_r.strap_s2[2];
    assign rq_route   = route_of(req_asi);
    assign req_ready  = (st_r.flush_left == 13'h0000);
    assign accept     = req_valid && req_ready;

    ccmcs_tags u_tags (
        .clk   (clk),
        .we    (st_r.flush_left != 13'h0000),
        .waddr (st_r.flush_line),
        .wdata (20'h00000),
        .raddr (accept ? req_addr[LINE_SHIFT +: 11] : st_r.tag_raddr),
        .rdata (tag_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        mine;
        logic        boot_all;
        logic [31:0] rd;
        logic [15:0] off;
        st_nxt   = st_r;
        mine     = 1'b0;
        boot_all = 1'b0;
        rd       = 32'h0000_0000;
        off      = req_addr[15:0];
        st_nxt.strap_s1 = {chip_select_strap, hold_strap, output_enable_strap};
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.evt_s1   = {wdog_reset_event, sw_int_reset_event, sw_ext_reset_event};
        st_nxt.evt_s2   = st_r.evt_s1;
        // straps caught two cycles after reset release
        if (st_r.strap_cnt != 2'h3) begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            if (st_r.strap_cnt == 2'h2) begin
                st_nxt.boot_mode = strap_boot;
            end
        end
        st_nxt.rsp_valid = 1'b0;
        st_nxt.bus_req   = 1'b0;
        st_nxt.diag_sel  = 1'b0;
        st_nxt.fault_signal = 1'b0;
        if (st_r.flush_left != 13'h0000) begin
            st_nxt.flush_left = st_r.flush_left - 13'h0001;
            st_nxt.flush_line = st_r.flush_line + 11'h001;
        end
        // reset cause, hardware set wins over software write
        if (accept && req_write && rq_route == CCMCS_ROUTE_CTRL && off == OFF_RST) begin
            st_nxt.reset_cause_reg = req_wdata[2:0];
        end
        if (st_r.evt_s2[2]) begin
            st_nxt.reset_cause_reg = RST_WDOG;
        end else if (st_r.evt_s2[1]) begin
            st_nxt.reset_cause_reg = RST_SIR;
        end else if (st_r.evt_s2[0]) begin
            st_nxt.reset_cause_reg = RST_SER;
        end
        // tlb replacement walk stays at or above the locked floor
        if (tlb_refill) begin
            if (st_r.replacement_counter == TLB_LAST) begin
                st_nxt.replacement_counter = st_r.initial_replacement_counter;
            end else begin
                st_nxt.replacement_counter = st_r.replacement_counter + 6'h01;
            end
        end
        if (st_r.replacement_counter < st_r.initial_replacement_counter) begin
            st_nxt.replacement_counter = st_r.initial_replacement_counter;
        end
        if (accept) begin
            boot_all = st_r.boot_mode && !mv && mc_mode;
            mine     = !mc_mode || in_slice || boot_all || st_r.boot_mode;
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_route = rq_route;
            st_nxt.rsp_mine  = mine;
            st_nxt.tag_raddr = req_addr[LINE_SHIFT +: 11];
            unique case (rq_route)
                CCMCS_ROUTE_CTRL: begin
                    unique case (off)
                        OFF_SCR:  rd = st_r.system_control_reg;
                        OFF_CONTEXT_TABLE_PTR_REG: rd = st_r.context_table_ptr_reg;
                        OFF_CXR:  rd = st_r.context_number_reg;
                        OFF_SYNC_FAULT_STATUS_REG: rd = st_r.sync_fault_status_reg;
                        OFF_SYNC_FAULT_ADDR_REG: rd = st_r.sync_fault_addr_reg;
                        OFF_ASYNC_FAULT_STATUS_REG: rd = st_r.async_fault_status_reg;
                        OFF_ASYNC_FAULT_ADDR_REG: rd = st_r.async_fault_addr_reg;
                        OFF_RST:  rd = {29'h0, st_r.reset_cause_reg};
                        OFF_RPR:  rd = st_r.root_table_ptr_reg;
                        OFF_INSTR_TABLE_PTR_REG: rd = st_r.instr_table_ptr_reg;
                        OFF_DATA_TABLE_PTR_REG: rd = st_r.data_table_ptr_reg;
                        OFF_ITR:  rd = st_r.index_tag_reg;
                        OFF_TLB_REPLACE_CTRL_REG: rd = {18'h0, st_r.initial_replacement_counter, 2'h0,
                                        st_r.replacement_counter};
                        default:  rd = 32'h0000_0000;
                    endcase
                    if (req_write) begin
                        unique case (off)
                            OFF_SCR:  st_nxt.system_control_reg = req_wdata & scr_mask;
                            OFF_CONTEXT_TABLE_PTR_REG: st_nxt.context_table_ptr_reg = req_wdata;
                            OFF_CXR:  st_nxt.context_number_reg = req_wdata;
                            OFF_RPR:  st_nxt.root_table_ptr_reg = req_wdata;
                            OFF_INSTR_TABLE_PTR_REG: st_nxt.instr_table_ptr_reg = req_wdata;
                            OFF_DATA_TABLE_PTR_REG: st_nxt.data_table_ptr_reg = req_wdata;
                            OFF_ITR:  st_nxt.index_tag_reg = req_wdata;
                            OFF_TLB_REPLACE_CTRL_REG: begin
                                st_nxt.replacement_counter = req_wdata[TLB_REPLACE_CTRL_REG_RC_LO +: 6];
                                st_nxt.initial_replacement_counter = req_wdata[TLB_REPLACE_CTRL_REG_IRC_LO +: 6];
                            end
                            default: ;
                        endcase
                    end
                end
                CCMCS_ROUTE_EXT, CCMCS_ROUTE_PASS: begin
                    // only the boot unit reaches memory in multichip mode; with multichip mode off any unit does
                    st_nxt.bus_req      = st_r.boot_mode || !mc_mode;
                    st_nxt.bus_addr     = req_addr;
                    st_nxt.bus_physical = 1'b1;
                end
                CCMCS_ROUTE_DIAG: begin
                    st_nxt.diag_sel = st_r.boot_mode || !mc_mode;
                end
                CCMCS_ROUTE_FLUSH: begin
                    if (mine) begin
                        st_nxt.flush_left = flush_lines(req_asi);
                        st_nxt.flush_line = req_addr[LINE_SHIFT +: 11];
                    end
                end
                CCMCS_ROUTE_NORMAL: begin
                    st_nxt.bus_req      = (st_r.boot_mode || !mc_mode) && !st_r.system_control_reg[SCR_CACHE_EN];
                    st_nxt.bus_addr     = req_addr;
                    st_nxt.bus_physical = !st_r.system_control_reg[SCR_MMU_EN];
                end
            endcase
            st_nxt.rsp_rdata = rd;
        end
        // fault capture with table-walk level; synchronous faults signalled unless suppressed, asynchronous never
        if (fault_event && (st_r.boot_mode || !mc_mode)) begin
            if (fault_async) begin
                st_nxt.async_fault_status_reg = {22'h0, fault_level, fault_type};
                st_nxt.async_fault_addr_reg   = fault_addr;
            end else begin
                st_nxt.sync_fault_status_reg  = {22'h0, fault_level, fault_type};
                st_nxt.sync_fault_addr_reg    = fault_addr;
                st_nxt.fault_signal = !st_r.system_control_reg[SCR_NOFAULT];
            end
        end
        if (rst) begin
            st_nxt = '0;
            st_nxt.system_control_reg = SCR_RESET;
            st_nxt.rsp_route = CCMCS_ROUTE_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    assign rsp_valid      = st_r.rsp_valid;
    // tag memory output is already registered and held on the accepted line
    assign rsp_rdata      = (st_r.rsp_route == CCMCS_ROUTE_DIAG) ? {12'h000, tag_rdata} : st_r.rsp_rdata;
    assign rsp_route      = st_r.rsp_route;
    assign rsp_mine       = st_r.rsp_mine;
    assign bus_req        = st_r.bus_req;
    assign bus_addr       = st_r.bus_addr;
    assign bus_physical   = st_r.bus_physical;
    assign diag_sel       = st_r.diag_sel;
    assign flush_busy     = (st_r.flush_left != 13'h0000);
    assign inst_cacheable = st_r.system_control_reg[SCR_MMU_EN] ? st_r.system_control_reg[SCR_CACHE_EN]
                                : st_r.system_control_reg[SCR_INS_CACH];
    assign data_cacheable = st_r.system_control_reg[SCR_MMU_EN] ? st_r.system_control_reg[SCR_CACHE_EN]
                                : st_r.system_control_reg[SCR_DAT_CACH];
    assign fault_signal   = st_r.fault_signal;
    assign fault_to_cpu   = st_r.fault_signal;
    assign cache_locked   = st_r.system_control_reg[SCR_LOCK];
    assign reflect_en     = st_r.system_control_reg[SCR_REFLECT];
    assign module_id      = st_r.system_control_reg[SCR_MID_HI:SCR_MID_LO];
    assign tlb_victim     = st_r.replacement_counter;

    ////////////////////////////////////////////////////////////////////
    sequence s_flush_start;
        req_valid && req_ready && route_of(req_asi) == CCMCS_ROUTE_FLUSH && req_asi == ASI_FLUSH_PAGE
            && (!mc_mode || in_slice || st_r.boot_mode);
    endsequence

    a_page_flush_len: assert property (@(posedge clk) disable iff (rst)
        s_flush_start |=> flush_busy [*8] ##56 flush_busy ##1 !flush_busy)
        else $error("page flush length wrong");
    a_ext_to_bus: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && req_asi == ASI_EXTENDED && !mc_mode |=> bus_req && bus_physical)
        else $error("extended access not sent to bus");
    a_pass_phys: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && req_asi[7:4] == 4'h2 |=> rsp_route == CCMCS_ROUTE_PASS && bus_addr == $past(req_addr))
        else $error("passthrough address changed");
    a_diag_sel: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && req_asi == ASI_TLB_DIAG && !mc_mode |=> diag_sel && !bus_req)
        else $error("diagnostic access not routed");
    a_victim_floor: assert property (@(posedge clk) disable iff (rst)
        tlb_refill && !(req_valid && req_ready) |=> tlb_victim >= st_r.initial_replacement_counter)
        else $error("locked tlb entry chosen");
    a_fault_mask: assert property (@(posedge clk) disable iff (rst)
        fault_event && !fault_async && st_r.system_control_reg[SCR_NOFAULT] |=> !fault_to_cpu)
        else $error("suppressed fault signalled");
    a_scr_write: assert property (@(posedge clk) disable iff (rst)
        req_valid && req_ready && req_write && req_asi == ASI_CTRL_SPACE && req_addr[15:0] == OFF_SCR
            |=> st_r.system_control_reg == ($past(req_wdata) & scr_mask))
        else $error("control register write lost");
    a_lock_variant: assert property (@(posedge clk) disable iff (rst)
        SNOOP_VARIANT |-> !cache_locked)
        else $error("cache lock in snooping variant");
endmodule : ccmcs_top
`default_nettype wire

/* include/ccmcs_pkg.sv */
// constants and types for the cache/mmu control space block
package ccmcs_pkg;
    // address space identifiers
    localparam logic [7:0] ASI_EXTENDED   = 8'h01;
    localparam logic [7:0] ASI_CTRL_SPACE = 8'h04;
    localparam logic [7:0] ASI_TLB_DIAG   = 8'h06;
    localparam logic [7:0] ASI_FLUSH_PAGE = 8'h10;
    localparam logic [7:0] ASI_FLUSH_SEG  = 8'h11;
    localparam logic [7:0] ASI_FLUSH_REG  = 8'h12;
    localparam logic [7:0] ASI_FLUSH_CTX  = 8'h13;
    localparam logic [7:0] ASI_FLUSH_USER = 8'h14;
    localparam logic [3:0] ASI_PASS_HI    = 4'h2;
    // control space register offsets
    localparam logic [15:0] OFF_SCR   = 16'h0000;
    localparam logic [15:0] OFF_CONTEXT_TABLE_PTR_REG  = 16'h0100;
    localparam logic [15:0] OFF_CXR   = 16'h0200;
    localparam logic [15:0] OFF_SYNC_FAULT_STATUS_REG  = 16'h0300;
    localparam logic [15:0] OFF_SYNC_FAULT_ADDR_REG  = 16'h0400;
    localparam logic [15:0] OFF_ASYNC_FAULT_STATUS_REG  = 16'h0500;
    localparam logic [15:0] OFF_ASYNC_FAULT_ADDR_REG  = 16'h0600;
    localparam logic [15:0] OFF_RST   = 16'h0700;
    localparam logic [15:0] OFF_RPR   = 16'h1000;
    localparam logic [15:0] OFF_INSTR_TABLE_PTR_REG  = 16'h1100;
    localparam logic [15:0] OFF_DATA_TABLE_PTR_REG  = 16'h1200;
    localparam logic [15:0] OFF_ITR   = 16'h1300;
    localparam logic [15:0] OFF_TLB_REPLACE_CTRL_REG  = 16'h1400;
    // system control fields
    localparam int SCR_MMU_EN   = 0;
    localparam int SCR_NOFAULT  = 1;
    localparam int SCR_CACHE_EN = 8;
    localparam int SCR_LOCK     = 9;
    localparam int SCR_COPYBACK = 10;
    localparam int SCR_REFLECT  = 11;
    localparam int SCR_MID_LO   = 15;
    localparam int SCR_MID_HI   = 18;
    localparam int SCR_INS_CACH = 19;
    localparam int SCR_DAT_CACH = 20;
    localparam int SCR_MC_MODE  = 21;
    localparam int SCR_MV       = 22;
    localparam int SCR_MCM_LO   = 23;
    localparam int SCR_MCA_LO   = 25;
    localparam logic [31:0] SCR_RESET       = 32'h0000_0000;
    localparam logic [31:0] SCR_MASK_BASE   = 32'h07F8_0703;
    localparam logic [31:0] SCR_MASK_SNOOP  = 32'h07FF_8D03;
    // replacement control fields
    localparam int TLB_REPLACE_CTRL_REG_RC_LO  = 0;
    localparam int TLB_REPLACE_CTRL_REG_IRC_LO = 8;
    localparam logic [5:0] TLB_LAST = 6'h3F;
    // cache geometry
    localparam logic [16:0] CACHE_BYTES    = 17'h10000;
    localparam int          LINE_BYTES     = 32;
    localparam int          LINE_SHIFT     = 5;
    localparam logic [12:0] LINES_PAGE     = 13'h0040;
    localparam logic [12:0] LINES_SEG      = 13'h0100;
    localparam logic [12:0] LINES_CTX      = 13'h1000;
    // reset cause codes
    localparam logic [2:0] RST_WDOG = 3'h4;
    localparam logic [2:0] RST_SIR  = 3'h2;
    localparam logic [2:0] RST_SER  = 3'h1;
    // fault level field position
    localparam int FSR_LVL_LO = 8;

    typedef enum logic [2:0] {
        CCMCS_ROUTE_NORMAL,
        CCMCS_ROUTE_EXT,
        CCMCS_ROUTE_CTRL,
        CCMCS_ROUTE_DIAG,
        CCMCS_ROUTE_FLUSH,
        CCMCS_ROUTE_PASS
    } ccmcs_route_t;

    typedef enum logic [2:0] {
        CCMCS_FL_PAGE,
        CCMCS_FL_SEG,
        CCMCS_FL_REGION,
        CCMCS_FL_CTX,
        CCMCS_FL_USER
    } ccmcs_flush_t;
endpackage : ccmcs_pkg

/* src/ccmcs_tags.sv */
// cache tag memory, one tag per 32-byte line, registered read
`timescale 1ns/1ps
`default_nettype none
module ccmcs_tags (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [10:0] waddr,
    input  wire logic [19:0] wdata,
    input  wire logic [10:0] raddr,
    output logic      [19:0] rdata
);
    logic [19:0] mem [0:2047];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : ccmcs_tags
`default_nettype wire

/* tb/ccmcs_cpu_model.sv */
// processor model issuing tagged accesses
`timescale 1ns/1ps
`default_nettype none
module ccmcs_cpu_model (
    input  wire logic        clk,
    input  wire logic        req_ready,
    input  wire logic [31:0] rsp_rdata,
    output logic             req_valid,
    output logic [7:0]       req_asi,
    output logic [31:0]      req_addr,
    output logic             req_write,
    output logic [31:0]      req_wdata
);
    initial begin
        {req_valid, req_asi, req_addr, req_write, req_wdata} = '0;
    end
    // held until taken, released lines show inverted data
    task access(input logic [7:0] asi, input logic [31:0] addr, input logic wr, input logic [31:0] wd,
                output logic [31:0] rd);
        @(negedge clk);
        {req_valid, req_asi, req_addr, req_write, req_wdata} = {1'b1, asi, addr, wr, wd};
        // a hang is caught by the bench watchdog
        while (req_ready !== 1'b1) begin
            @(negedge clk);
        end
        @(negedge clk);
        rd = rsp_rdata;
        {req_valid, req_addr, req_wdata} = {1'b0, ~addr, ~wd};
    endtask : access
endmodule : ccmcs_cpu_model
`default_nettype wire

/* tb/ccmcs_top_test.sv */
// self-checking bench for the control space block
`timescale 1ns/1ps
`default_nettype none
module ccmcs_top_test;
    import ccmcs_pkg::*;
    logic         clk, rst, req_valid, req_write, req_ready, bus_physical, flush_busy, tlb_refill;
    logic         rsp_valid, rsp_mine, bus_req, diag_sel, fault_signal, fault_to_cpu;
    logic [3:0]   module_id;
    logic [5:0]   tlb_victim;
    logic         inst_cacheable, data_cacheable, cache_locked, reflect_en, fault_event, fault_async;
    logic [1:0]   fault_level;
    logic [2:0]   rst_ev;
    logic [7:0]   req_asi, fault_type;
    logic [31:0]  req_addr, req_wdata, rsp_rdata, fault_addr, rd, bus_addr;
    ccmcs_route_t rsp_route;
    int           fail_count = 0;
    int           checked = 0;
    int           n;
    localparam logic [15:0] RW_OFF [6] = '{OFF_CONTEXT_TABLE_PTR_REG, OFF_CXR, OFF_RPR, OFF_INSTR_TABLE_PTR_REG, OFF_DATA_TABLE_PTR_REG, OFF_ITR};
    localparam logic [7:0] RT_ASI [4] = '{ASI_EXTENDED, ASI_TLB_DIAG, 8'h20, 8'h2F};
    localparam ccmcs_route_t RT_EXP [4] = '{CCMCS_ROUTE_EXT, CCMCS_ROUTE_DIAG, CCMCS_ROUTE_PASS, CCMCS_ROUTE_PASS};
    localparam logic [7:0] FL_ASI [5] = '{ASI_FLUSH_PAGE, ASI_FLUSH_SEG, ASI_FLUSH_REG, ASI_FLUSH_CTX, ASI_FLUSH_USER};
    localparam logic [12:0] FL_LEN [5] = '{LINES_PAGE, LINES_SEG, LINES_CTX, LINES_CTX, LINES_CTX};
    ccmcs_top #(.SNOOP_VARIANT(1'b0)) DUT (.clk, .rst, .req_valid, .req_asi, .req_addr, .req_write, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .rsp_route, .rsp_mine, .bus_req, .bus_addr, .bus_physical,
        .diag_sel, .flush_busy, .inst_cacheable, .data_cacheable, .fault_signal, .fault_to_cpu,
        .cache_locked, .reflect_en, .module_id, .tlb_victim, .chip_select_strap(1'b1), .hold_strap(1'b0),
        .output_enable_strap(1'b1), .tlb_refill, .fault_event, .fault_async, .fault_level, .fault_type,
        .fault_addr, .wdog_reset_event(rst_ev[2]), .sw_int_reset_event(rst_ev[1]), .sw_ext_reset_event(rst_ev[0]));
    ccmcs_cpu_model cpu (.clk, .req_ready, .rsp_rdata, .req_valid, .req_asi, .req_addr, .req_write, .req_wdata);
    ////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task rd_chk(input logic [15:0] off, input logic [31:0] exp);
        cpu.access(ASI_CTRL_SPACE, {16'h0, off}, 1'b0, 32'h0, rd);
        chk("ctrl reg", exp, rd);
        chk("rsp valid", 32'h1, {31'h0, rsp_valid});
    endtask : rd_chk
    task wr(input logic [15:0] off, input logic [31:0] d);
        cpu.access(ASI_CTRL_SPACE, {16'h0, off}, 1'b1, d, rd);
    endtask : wr
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #120000;
        fail_count++;
        end_sim();
    end
    initial begin
        {rst, tlb_refill, fault_event, fault_async, fault_level, fault_type, fault_addr, rst_ev} = '1;
        {tlb_refill, fault_event, rst_ev} = '0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_chk(OFF_SCR, SCR_RESET);
        foreach (RW_OFF[i]) begin
            wr(RW_OFF[i], 32'hC3A5_5A3C);
            rd_chk(RW_OFF[i], 32'hC3A5_5A3C);
        end
        wr(OFF_TLB_REPLACE_CTRL_REG, 32'h0000_0A3F);
        rd_chk(OFF_TLB_REPLACE_CTRL_REG, 32'h0000_0A3F);
        @(negedge clk);
        tlb_refill = 1'b1;
        @(negedge clk);
        tlb_refill = 1'b0;
        chk("victim", 32'h0000_000A, {26'h0, tlb_victim});
        rd_chk(OFF_TLB_REPLACE_CTRL_REG, 32'h0000_0A0A);
        wr(OFF_SYNC_FAULT_STATUS_REG, 32'hFFFF_FFFF);
        rd_chk(OFF_SYNC_FAULT_STATUS_REG, 32'h0);
        wr(16'h0800, 32'hFFFF_FFFF);
        rd_chk(16'h0800, 32'h0);
        wr(OFF_SCR, 32'h0008_0000);
        chk("icache", 32'h1, {31'h0, inst_cacheable});
        chk("dcache", 32'h0, {31'h0, data_cacheable});
        foreach (RT_ASI[i]) begin
            cpu.access(RT_ASI[i], 32'h0001_2340, 1'b0, 32'h0, rd);
            chk("route", 32'(RT_EXP[i]), 32'(rsp_route));
            chk("physical", RT_EXP[i] == CCMCS_ROUTE_DIAG ? 32'h1 : 32'h2, 32'({bus_req & bus_physical, diag_sel}));
            chk("bus addr", 32'h0001_2340, bus_addr);
        end
        foreach (FL_ASI[i]) begin
            cpu.access(FL_ASI[i], 32'h0, 1'b0, 32'h0, rd);
            chk("route", 32'(CCMCS_ROUTE_FLUSH), 32'(rsp_route));
            chk("mine", 32'h1, {31'h0, rsp_mine});
            n = 0;
            while (flush_busy === 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            chk("flush len", 32'(FL_LEN[i]), 32'(n));
        end
        cpu.access(ASI_TLB_DIAG, 32'h0001_2340, 1'b0, 32'h0, rd);
        chk("diag tag", 32'h0, rd);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            {fault_event, fault_async, fault_level, fault_type, fault_addr} =
                {1'b1, 1'(i), 2'h2, 8'(8'h5A + i), 32'hDEAD_0000 + i};
            @(negedge clk);
            fault_event = 1'b0;
            chk("fault out", i ? 32'h0 : 32'h3, {30'h0, fault_signal, fault_to_cpu});
            rd_chk(i ? OFF_ASYNC_FAULT_STATUS_REG : OFF_SYNC_FAULT_STATUS_REG, {22'h0, 2'h2, 8'(8'h5A + i)});
            rd_chk(i ? OFF_ASYNC_FAULT_ADDR_REG : OFF_SYNC_FAULT_ADDR_REG, 32'hDEAD_0000 + i);
        end
        for (int i = 0; i < 3; i++) begin
            rst_ev = 3'h4 >> i;
            repeat (4) @(negedge clk);
            rd_chk(OFF_RST, {29'h0, 3'h4 >> i});
            rst_ev = 3'h0;
            repeat (4) @(negedge clk);
            wr(OFF_RST, 32'h0);
        end
        rd_chk(OFF_RST, 32'h0);
        wr(OFF_SCR, 32'hFFFF_FFFF);
        rd_chk(OFF_SCR, SCR_MASK_BASE);
        chk("lock", 32'h1, {31'h0, cache_locked});
        chk("reflect", 32'h0, {31'h0, reflect_en});
        chk("module id", 32'h0, {28'h0, module_id});
        @(negedge clk);
        {fault_event, fault_async} = 2'b10;
        @(negedge clk);
        fault_event = 1'b0;
        chk("fault out", 32'h0, {30'h0, fault_signal, fault_to_cpu});
        end_sim();
    end
endmodule : ccmcs_top_test
`default_nettype wire
